// file: nsw_pkg.sv
// Purpose: Shared constants for the byte-instruction execute block
// Assumes: 8-bit data path, 12-bit file address, 22-bit table pointer
// Notes:   Opcode fields follow the 16-bit instruction word layout
package nsw_pkg;
	// ==========================================================
	// Opcode patterns
	localparam logic [5:0]  OPC_SWAP      = 6'h0E;
	localparam logic [5:0]  OPC_SUBB      = 6'h16;
	localparam logic [13:0] OPC_TABLE_WRITE_OP     = 14'h0003;
	// ==========================================================
	// Field positions and address decode limits
	localparam int          DEST_BIT      = 9;
	localparam int          ACC_BIT       = 8;
	localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
	localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
	localparam logic [3:0]  ACCESS_HIGH   = 4'hF;
	// ==========================================================
	// Status flag bit positions
	localparam int          FLG_C         = 0;
	localparam int          FLG_DC        = 1;
	localparam int          FLG_Z         = 2;
	localparam int          FLG_OV        = 3;
	localparam int          FLG_N         = 4;
	// ==========================================================
	// Table pointer modes
	localparam logic [1:0]  TM_NONE       = 2'h0;
	localparam logic [1:0]  TM_POSTINC    = 2'h1;
	localparam logic [1:0]  TM_POSTDEC    = 2'h2;
	localparam logic [1:0]  TM_PREINC     = 2'h3;
	// ==========================================================
	// Reset values
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [21:0] RST_PTR       = 22'h000000;
	localparam logic [4:0]  RST_FLAGS     = 5'h00;

	typedef enum logic [1:0] {
		NSW_IDLE,
		NSW_TBL2
	} nsw_state_t;
endpackage

// file: nsw_alu.sv
// Purpose: Combinational result and flags for swap and subtract-with-borrow
// Assumes: Operands are stable while the instruction executes
// Notes:   Flags returned as {N,OV,Z,DC,C}
`timescale 1ns/1ns
`default_nettype none
module nsw_alu (
	input  wire logic       i_is_sub,
	input  wire logic [7:0] i_f,
	input  wire logic [7:0] i_w,
	input  wire logic       i_carry,
	output logic      [7:0] o_result,
	output logic      [4:0] o_flags
);
	logic [8:0] diff;
	logic [4:0] lo;
	always_comb begin
		// f + ~w + c equals f - w - !c in two's complement
		diff     = {1'b0, i_f} + {1'b0, ~i_w} + {8'h00, i_carry};
		lo       = {1'b0, i_f[3:0]} + {1'b0, ~i_w[3:0]} + {4'h0, i_carry};
		o_flags  = '0;
		if (i_is_sub) begin
			o_result = diff[7:0];
			o_flags[nsw_pkg::FLG_C]  = diff[8];
			o_flags[nsw_pkg::FLG_DC] = lo[4];
			o_flags[nsw_pkg::FLG_Z]  = (diff[7:0] == 8'h00);
			o_flags[nsw_pkg::FLG_OV] = (i_f[7] != i_w[7]) && (diff[7] != i_f[7]);
			o_flags[nsw_pkg::FLG_N]  = diff[7];
		end else begin
			o_result = {i_f[3:0], i_f[7:4]};
		end
	end
endmodule // nsw_alu
`default_nettype wire

// file: nsw_exec.sv
// Purpose: Execute swap, subtract-with-borrow and table write
// Assumes: One instruction presented per i_valid pulse; file data read same cycle
// Notes:   Table write holds busy for its second cycle
// Summary of operation
// - Swap exchanges nibbles, flags unchanged
// - Destination bit 0 accumulator, 1 file
// - Access bit 0 access bank, 1 bank-selected
// - Indexed literal offset when a=0, extended, f<=5Fh
// - Subtract with borrow updates N,OV,C,DC,Z
`timescale 1ns/1ns
`default_nettype none
module nsw_exec (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_valid,
	input  wire logic [15:0] i_instr,
	input  wire logic        i_ext_en,
	input  wire logic [3:0]  i_bank_select_register,
	input  wire logic [11:0] i_index_base,
	input  wire logic [7:0]  i_file_rdata,
	input  wire logic [7:0]  i_table_latch,
	output logic      [11:0] o_file_addr,
	output logic      [7:0]  o_file_wdata,
	output logic             o_file_we,
	output logic      [7:0]  o_wreg,
	output logic      [4:0]  o_status,
	output logic      [21:0] o_table_pointer,
	output logic      [21:0] o_hold_addr,
	output logic      [7:0]  o_hold_data,
	output logic             o_hold_we,
	output logic             o_busy
);
	// ==========================================================
	// Decode
	nsw_pkg::nsw_state_t state;
	logic        idle;
	logic        is_swap;
	logic        is_sub;
	logic        is_tbl;
	logic        is_byte;
	logic        to_file;
	logic [7:0]  fld;
	logic [11:0] next_addr;
	logic [7:0]  alu_res;
	logic [4:0]  alu_flg;
	logic [1:0]  tmode;

	// Match of the six opcode bits shared by the byte-oriented instructions
	function automatic logic byte_op_match(
		input logic [15:0] instr,
		input logic [5:0]  opcode
	);
		return instr[15:10] == opcode;
	endfunction

	// Pointer after one step; the first cycle moves only for pre-increment
	function automatic logic [21:0] ptr_step(
		input logic [21:0] ptr,
		input logic [1:0]  mode,
		input logic        first
	);
		logic [21:0] res;
		res = ptr;
		if (first) begin
			if (mode == nsw_pkg::TM_PREINC) begin
				res = ptr + 22'h000001;
			end
		end else begin
			case (mode)
				nsw_pkg::TM_POSTINC: begin
					res = ptr + 22'h000001;
				end
				nsw_pkg::TM_POSTDEC: begin
					res = ptr - 22'h000001;
				end
				default: begin
					res = ptr;
				end
			endcase
		end
		return res;
	endfunction

	// New instructions are taken only while no table write is in flight
	assign fld     = i_instr[7:0];
	assign idle    = (state == nsw_pkg::NSW_IDLE);
	assign is_swap = i_valid && idle && byte_op_match(i_instr, nsw_pkg::OPC_SWAP);
	assign is_sub  = i_valid && idle && byte_op_match(i_instr, nsw_pkg::OPC_SUBB);
	assign is_tbl  = i_valid && idle && (i_instr[15:2] == nsw_pkg::OPC_TABLE_WRITE_OP);
	assign is_byte = is_swap || is_sub;
	assign to_file = i_instr[nsw_pkg::DEST_BIT];

	always_comb begin
		if (i_instr[nsw_pkg::ACC_BIT]) begin
			next_addr = {i_bank_select_register, fld};
		end else if (i_ext_en && fld <= nsw_pkg::IDX_LIMIT) begin
			next_addr = i_index_base + {4'h0, fld};
		end else if (fld < nsw_pkg::ACCESS_SPLIT) begin
			next_addr = {4'h0, fld};
		end else begin
			next_addr = {nsw_pkg::ACCESS_HIGH, fld};
		end
	end

	nsw_alu u_alu (
		.i_is_sub (is_sub),
		.i_f      (i_file_rdata),
		.i_w      (o_wreg),
		.i_carry  (o_status[nsw_pkg::FLG_C]),
		.o_result (alu_res),
		.o_flags  (alu_flg)
	);

	// ==========================================================
	// File address register
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_file_addr <= 12'h000;
		end else if (is_swap || is_sub) begin
			o_file_addr <= next_addr;
		end
	end

	// ==========================================================
	// File write strobe
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_file_we <= 1'b0;
		end else begin
			o_file_we <= is_byte && to_file;
		end
	end

	// ==========================================================
	// File write data
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_file_wdata <= nsw_pkg::RST_BYTE;
		end else if (is_byte && to_file) begin
			o_file_wdata <= alu_res;
		end
	end

	// ==========================================================
	// Accumulator
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wreg <= nsw_pkg::RST_BYTE;
		end else if (is_byte && !to_file) begin
			o_wreg <= alu_res;
		end
	end

	// ==========================================================
	// Status flags
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_status <= nsw_pkg::RST_FLAGS;
		end else if (is_sub) begin
			o_status <= alu_flg;
		end
	end

	// ==========================================================
	// Table write sequence
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= nsw_pkg::NSW_IDLE;
		end else begin
			case (state)
				nsw_pkg::NSW_IDLE: begin
					if (is_tbl) begin
						state <= nsw_pkg::NSW_TBL2;
					end
				end
				nsw_pkg::NSW_TBL2: begin
					state <= nsw_pkg::NSW_IDLE;
				end
				default: begin
					state <= nsw_pkg::NSW_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Pointer mode held for the second cycle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tmode <= nsw_pkg::TM_NONE;
		end else if (is_tbl) begin
			tmode <= i_instr[1:0];
		end
	end

	// ==========================================================
	// Busy covers the second table write cycle; requests then are ignored
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= is_tbl;
		end
	end

	// ==========================================================
	// Holding register write
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hold_we   <= 1'b0;
			o_hold_addr <= nsw_pkg::RST_PTR;
			o_hold_data <= nsw_pkg::RST_BYTE;
		end else begin
			o_hold_we <= (state == nsw_pkg::NSW_TBL2);
			if (state == nsw_pkg::NSW_TBL2) begin
				o_hold_addr <= o_table_pointer;
				o_hold_data <= i_table_latch;
			end
		end
	end

	// ==========================================================
	// Table pointer: pre-increment in the first cycle, post steps in the second
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_table_pointer <= nsw_pkg::RST_PTR;
		end else if (is_tbl) begin
			o_table_pointer <= ptr_step(o_table_pointer, i_instr[1:0], 1'b1);
		end else if (state == nsw_pkg::NSW_TBL2) begin
			o_table_pointer <= ptr_step(o_table_pointer, tmode, 1'b0);
		end
	end
endmodule // nsw_exec
`default_nettype wire

// file: nsw_exec_assertions.sv
// Purpose: Port checks for the execute block
// Assumes: Single clock, reset active low
// Notes:   Bound to every nsw_exec
`timescale 1ns/1ns
`default_nettype none
module nsw_chk (
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic        i_valid,
	input wire logic [15:0] i_instr,
	input wire logic        i_ext_en,
	input wire logic [3:0]  i_bank_select_register,
	input wire logic [11:0] i_index_base,
	input wire logic [7:0]  i_file_rdata,
	input wire logic [7:0]  i_table_latch,
	input wire logic [11:0] o_file_addr,
	input wire logic [7:0]  o_file_wdata,
	input wire logic        o_file_we,
	input wire logic [7:0]  o_wreg,
	input wire logic [4:0]  o_status,
	input wire logic [21:0] o_table_pointer,
	input wire logic [21:0] o_hold_addr,
	input wire logic [7:0]  o_hold_data,
	input wire logic        o_hold_we,
	input wire logic        o_busy
);
	// ==========================================================
	// Decode of taken instructions
	wire       tk = i_valid && !o_busy;
	wire       sw = tk && i_instr[15:10] == nsw_pkg::OPC_SWAP;
	wire       sb = tk && i_instr[15:10] == nsw_pkg::OPC_SUBB;
	wire       tw = tk && i_instr[15:2] == nsw_pkg::OPC_TABLE_WRITE_OP;
	wire [7:0] sf = {i_file_rdata[3:0], i_file_rdata[7:4]};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// ==========================================================
	// Properties
	chk_swap_file: assert property (sw && i_instr[9] |=> o_file_we && o_file_wdata == $past(sf))
		else $error("swap file result wrong");
	chk_swap_acc: assert property (sw && !i_instr[9] |=> !o_file_we && o_wreg == $past(sf))
		else $error("swap accumulator result wrong");
	chk_swap_flags: assert property (sw |=> $stable(o_status))
		else $error("swap changed flags");
	chk_bank_addr: assert property ((sw || sb) && i_instr[9:8] == 2'h3
		|=> o_file_addr == {$past(i_bank_select_register), $past(i_instr[7:0])}) else $error("bank address");
	chk_index_addr: assert property ((sw || sb) && i_instr[9:8] == 2'h2 && i_ext_en
		&& i_instr[7:0] <= nsw_pkg::IDX_LIMIT |=> o_file_addr == $past(i_index_base)
		+ $past(i_instr[7:0])) else $error("indexed address");
	chk_sub_carry: assert property (sb |=> o_status[0] == ($past({1'b0, i_file_rdata})
		>= $past({1'b0, o_wreg}) + $past(!o_status[0]))) else $error("borrow carry");
	chk_hold_copy: assert property (tw |=> o_busy ##1 (o_hold_we && !o_busy
		&& o_hold_data == $past(i_table_latch))) else $error("holding copy");
	chk_ptr_post: assert property (tw && i_instr[1:0] == 2'h1 |=> ##1 o_hold_addr
		== $past(o_table_pointer, 2) && o_table_pointer == $past(o_table_pointer, 2) + 22'h1)
		else $error("post increment");
	chk_ptr_pre: assert property (tw && i_instr[1:0] == 2'h3 |=> o_table_pointer
		== $past(o_table_pointer) + 22'h1 ##1 o_hold_addr == $past(o_table_pointer))
		else $error("pre increment");
	chk_busy_refuse: assert property (o_busy |=> !o_file_we && $stable(o_wreg)
		&& $stable(o_status)) else $error("request taken while busy");
endmodule // nsw_chk
bind nsw_exec nsw_chk u_chk (.*);
`default_nettype wire

// file: nsw_exec_tb.sv
// Purpose: Self-checking bench for the execute block
// Assumes: Behavioural model of accumulator, flags and pointer
// Notes:   Random operands from xorshift
`timescale 1ns/1ns
`default_nettype none
module nsw_exec_tb;
	logic        i_clk = 0, i_resetn = 0, i_valid = 0, i_ext_en = 0;
	logic [15:0] i_instr = 16'h0000;
	logic [3:0]  i_bank_select_register = 4'h0;
	logic [11:0] i_index_base = 12'h000, o_file_addr;
	logic [7:0]  i_file_rdata = 8'h00, i_table_latch = 8'h00, o_file_wdata, o_wreg, o_hold_data;
	logic [7:0]  w = 8'h00;
	logic [4:0]  o_status, st = 5'h00;
	logic [21:0] o_table_pointer, o_hold_addr, ptr = 22'h000000;
	logic        o_file_we, o_hold_we, o_busy;
	logic [31:0] seed = 32'hE0F1;
	int          err_count = 0, n_tests = 0;
	nsw_exec uut (.*);
	always #10 i_clk = ~i_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [21:0] seen, input logic [21:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ==========================================================
	// Swap, subtract-with-borrow and unknown opcodes
	task automatic byte_op(input logic [5:0] op);
		logic [31:0] x;
		logic [7:0]  f, fv, rb;
		logic [11:0] ea;
		logic        kn;
		x = rnd();
		f = x[7:0];
		fv = x[17:10];
		kn = op != 6'h3F;
		@(posedge i_clk);
		i_valid <= 1;
		i_instr <= {op, x[9:0]};
		i_file_rdata <= fv;
		i_ext_en <= x[18];
		i_bank_select_register <= x[22:19];
		i_index_base <= x[31:20];
		@(posedge i_clk);
		i_valid <= 0;
		ea = x[8] ? {x[22:19], f} : (x[18] && f <= 8'h5F) ? x[31:20] + f : {{4{f >= 8'h60}}, f};
		rb = (op == nsw_pkg::OPC_SWAP) ? {fv[3:0], fv[7:4]} : fv - w - {7'h00, !st[0]};
		if (op == nsw_pkg::OPC_SUBB) begin
			st = {rb[7], fv[7] != w[7] && rb[7] != fv[7], rb == 8'h00,
				{1'b0, fv[3:0]} >= w[3:0] + !st[0], {1'b0, fv} >= w + !st[0]};
		end
		#1 chk("file_we", o_file_we, kn && x[9]);
		if (kn && x[9]) chk("file_addr", o_file_addr, ea);
		if (kn && x[9]) chk("file_wdata", o_file_wdata, rb);
		if (kn && !x[9]) w = rb;
		chk("wreg", o_wreg, w);
		chk("status", o_status, st);
	endtask
	// ==========================================================
	// Table write in each pointer mode
	task automatic tbl(input logic [1:0] m);
		logic [7:0]  lv;
		logic [21:0] ha;
		lv = 8'(rnd());
		ha = (m == nsw_pkg::TM_PREINC) ? ptr + 22'h1 : ptr;
		@(posedge i_clk);
		i_valid <= 1;
		i_instr <= {nsw_pkg::OPC_TABLE_WRITE_OP, m};
		i_table_latch <= lv;
		@(posedge i_clk);
		i_instr <= {nsw_pkg::OPC_SWAP, 2'h3, 8'(rnd())};
		#1 chk("busy", o_busy, 1'b1);
		@(posedge i_clk);
		i_valid <= 0;
		#1 chk("hold_we", o_hold_we, 1'b1);
		chk("refused_we", o_file_we, 1'b0);
		chk("hold_addr", o_hold_addr, ha);
		chk("hold_data", o_hold_data, lv);
		ptr = (m == nsw_pkg::TM_POSTDEC) ? ptr - 22'h1 : (m == nsw_pkg::TM_NONE) ? ptr : ptr + 22'h1;
		chk("pointer", o_table_pointer, ptr);
		chk("busy_end", o_busy, 1'b0);
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		i_resetn <= 1;
		for (int k = 0; k < 90; k++) byte_op(k % 3 == 2 ? 6'h3F : k % 2 ? nsw_pkg::OPC_SUBB : nsw_pkg::OPC_SWAP);
		$display("Byte instruction test done");
		for (int k = 0; k < 8; k++) tbl(k[1:0]);
		$display("Table write test done");
		complete_run();
	end
endmodule // nsw_exec_tb
`default_nettype wire
